/* File: logic/stg_defines.vh */
// register offsets, field positions, reset values and timing counts for the tone generator
`ifndef STG_DEFINES_VH
`define STG_DEFINES_VH

// register byte offsets
`define STG_CTRL0_OFFSET    12'h000
`define STG_CTRL1_OFFSET    12'h004
`define STG_STATUS_OFFSET   12'h008
`define STG_DUTY_OFFSET     12'h00C

// control register fields
`define STG_DIV_LSB         0
`define STG_DIV_MSB         15
`define STG_CHAN_LSB        16
`define STG_CHAN_MSB        19
`define STG_START_BIT       24
`define STG_STOP_BIT        25

// reset values
`define STG_DIV_RESET       16'h0000
`define STG_CHAN_RESET      4'h0
`define STG_DUTY_RESET      16'h0000

// reference tick rate and system clock
`define STG_REF_HZ          2304000
`define STG_CLK_HZ          100000000
`define STG_ACC_W           27

// channel count and group bases
`define STG_NCHAN           16
`define STG_GRP0_CHAN       4'h0
`define STG_GRP1_CHAN       4'h3

`endif

/* File: logic/stg_tone_gen.v */
// square-wave tone generator on two shared pulse-channel timers, APB slave
//
// Register access over APB and the register addresses are this design's own decisions.
`include "stg_defines.vh"

module stg_tone_gen (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // pulse channel pins and their output enables (set by software pin config)
  input  wire [15:0] pinOutputMode,
  output reg  [15:0] pulseOut
);

  // per group control
  reg [15:0] div0_reg;
  reg [15:0] div1_reg;
  reg [3:0]  chan0_reg;
  reg [3:0]  chan1_reg;
  reg        run0_reg;
  reg        run1_reg;
  reg [15:0] duty_reg;   // plain pulse output levels for channels not blocked
  reg [`STG_ACC_W-1:0] acc_reg;
  reg        refTick_reg;
  // accumulator step and wrap, cut back to the accumulator width on purpose
  wire [31:0] accSum  = {5'h00, acc_reg} + `STG_REF_HZ + `STG_REF_HZ;
  wire [31:0] accWrap = accSum - `STG_CLK_HZ;
  wire       wave0;
  wire       wave1;

  // access phase of an apb transfer; answered after one wait state
  wire       access = psel && penable && !pready;
  wire       wr     = psel && penable && pready && pwrite; // lands on the completing edge

  // group of a channel: 0 for 0..2, 1 for 3..5, 2 for none
  function [1:0] grpOf;
    input [3:0] ch;
    begin
      if (ch <= 4'h2) grpOf = 2'h0;
      else if (ch <= 4'h5) grpOf = 2'h1;
      else grpOf = 2'h2;
    end
  endfunction

  // fractional accumulator ticking at twice the reference rate, since the
  // timer toggles once per divisor ticks and a period needs two toggles
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg     <= {`STG_ACC_W{1'b0}};
      refTick_reg <= 1'b0;
    end else if (accSum >= `STG_CLK_HZ) begin
      acc_reg     <= accWrap[`STG_ACC_W-1:0];
      refTick_reg <= 1'b1;
    end else begin
      acc_reg     <= accSum[`STG_ACC_W-1:0];
      refTick_reg <= 1'b0;
    end
  end

  // control register writes; start and stop are actions, stop reads back zero and the start bit reads back the run state
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div0_reg  <= `STG_DIV_RESET;
      div1_reg  <= `STG_DIV_RESET;
      chan0_reg <= `STG_CHAN_RESET;
      chan1_reg <= `STG_CHAN_RESET;
      run0_reg  <= 1'b0;
      run1_reg  <= 1'b0;
      duty_reg  <= `STG_DUTY_RESET;
    end else if (wr) begin
      if (paddr == `STG_CTRL0_OFFSET) begin
        div0_reg  <= pwdata[`STG_DIV_MSB:`STG_DIV_LSB];
        chan0_reg <= pwdata[`STG_CHAN_MSB:`STG_CHAN_LSB];
        if (pwdata[`STG_STOP_BIT])
          run0_reg <= 1'b0;
        else if (pwdata[`STG_START_BIT])
          run0_reg <= 1'b1;
      end else if (paddr == `STG_CTRL1_OFFSET) begin
        div1_reg  <= pwdata[`STG_DIV_MSB:`STG_DIV_LSB];
        chan1_reg <= pwdata[`STG_CHAN_MSB:`STG_CHAN_LSB];
        if (pwdata[`STG_STOP_BIT])
          run1_reg <= 1'b0;
        else if (pwdata[`STG_START_BIT])
          run1_reg <= 1'b1;
      end else if (paddr == `STG_DUTY_OFFSET) begin
        duty_reg <= pwdata[15:0];
      end
    end
  end

  // independent timers, one per group
  stg_tone_timer uTimer0 (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .refTick      (refTick_reg),
    .runEn        (run0_reg),
    .divisorValue (div0_reg),
    .waveOut      (wave0)
  );

  stg_tone_timer uTimer1 (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .refTick      (refTick_reg),
    .runEn        (run1_reg),
    .divisorValue (div1_reg),
    .waveOut      (wave1)
  );

  // per channel output: tone on the selected channel, blocked group low,
  // otherwise plain level; pins not set to output stay low
  genvar gi;
  generate
    for (gi = 0; gi < `STG_NCHAN; gi = gi + 1) begin : gCh
      localparam integer CH = gi;
      wire [1:0] g = grpOf(CH[3:0]);
      wire blk0 = run0_reg && (g == 2'h0);
      wire blk1 = run1_reg && (g == 2'h1);
      wire tone0 = run0_reg && (chan0_reg == CH[3:0]);
      wire tone1 = run1_reg && (chan1_reg == CH[3:0]);
      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
          pulseOut[gi] <= 1'b0;
        else if (!pinOutputMode[gi])
          pulseOut[gi] <= 1'b0;
        else if (tone0)
          pulseOut[gi] <= wave0;
        else if (tone1)
          pulseOut[gi] <= wave1;
        else if (blk0 || blk1)
          pulseOut[gi] <= 1'b0;
        else
          pulseOut[gi] <= duty_reg[gi];
      end
    end
  endgenerate

  // apb answer: one wait state, unmapped addresses answer with an error
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (access) begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (paddr == `STG_CTRL0_OFFSET)
        prdata <= {6'h00, 1'b0, run0_reg, 4'h0, chan0_reg, div0_reg};
      else if (paddr == `STG_CTRL1_OFFSET)
        prdata <= {6'h00, 1'b0, run1_reg, 4'h0, chan1_reg, div1_reg};
      else if (paddr == `STG_STATUS_OFFSET)
        prdata <= {28'h0000000, wave1, wave0, run1_reg, run0_reg};
      else if (paddr == `STG_DUTY_OFFSET)
        prdata <= {16'h0000, duty_reg};
      else
        pslverr <= 1'b1;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule // stg_tone_gen

/* File: logic/stg_tone_timer.v */
// one shared divisor timer producing a square wave toggle per reload
`include "stg_defines.vh"

module stg_tone_timer (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst_n,
  // reference tick enable
  input  wire        refTick,
  // control
  input  wire        runEn,
  input  wire [15:0] divisorValue,
  // output
  output reg         waveOut
);

  reg [15:0] count_reg;

  // count ticks; toggle and reload when the divisor is reached
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 16'h0000;
      waveOut   <= 1'b0;
    end else if (!runEn || divisorValue == 16'h0000) begin
      count_reg <= 16'h0000;
      waveOut   <= 1'b0;
    end else if (refTick) begin
      if (count_reg + 16'h0001 >= divisorValue) begin
        count_reg <= 16'h0000;
        waveOut   <= ~waveOut;
      end else begin
        count_reg <= count_reg + 16'h0001;
      end
    end
  end

endmodule // stg_tone_timer

/* File: tb/stg_load_model.sv */
// load on one tone pin: measures cycles between toggles
module stg_load_model (
  // clock and pin
  input wire logic sys_clk,
  input wire logic pin,
  // last half period and toggle count
  output int       halfLen,
  output int       edges
);
  timeunit 1ns;
  timeprecision 1ps;
  int   cnt = 0;
  logic prev = 1'b0;
  // count cycles between level changes
  always @(posedge sys_clk) begin
    cnt++;
    if (pin !== prev) begin
      halfLen = cnt;
      edges++;
      cnt = 0;
    end
    prev = pin;
  end
endmodule // stg_load_model

/* File: tb/stg_tone_checker.sv */
// port checks for the tone generator
module stg_tone_checker (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins
  input wire logic [15:0] pinOutputMode,
  input wire logic [15:0] pulseOut
);
  timeunit 1ns;
  timeprecision 1ps;
  // all checks on the system clock, off in reset
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  answer_wait_a: assert property (psel && penable && !pready |=> pready) else $error("no answer");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
  ready_access_a: assert property (pready |-> psel && penable) else $error("stray ready");
  ready_cause_a: assert property (!(psel && penable) |=> !pready) else $error("ready uncaused");
  err_decode_a: assert property (pready |-> pslverr == !(paddr == 12'h000 || paddr == 12'h004
    || paddr == 12'h008 || paddr == 12'h00C)) else $error("bad error");
  err_rdzero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("bad data");
  pin_gate_a:
    assert property ($stable(pinOutputMode) |-> (pulseOut & ~pinOutputMode) == 16'h0)
    else $error("input pin driven");
  reset_quiet_a: assert property ($rose(rst_n) |-> pulseOut == 16'h0) else $error("pins live");
  // main scenarios reached
  cover property (pslverr);
  cover property ($changed(pulseOut[1]));
  cover property ($changed(pulseOut[4]));
endmodule // stg_tone_checker

// attach to the tone generator
bind stg_tone_gen stg_tone_checker i_chk (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .pinOutputMode, .pulseOut);

/* File: tb/tb_top.sv */
// tone generator testbench: apb driver, expected figures, two pin loads
`include "stg_defines.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
  $display("mismatch t=%0t got %0h exp %0h", $time, a, b); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, er;
  logic [15:0] pinOutputMode = 16'hFFFF, pulseOut; // pins are outputs before any tone
  int          bad_count = 0, n_tests = 0, h1, e1, h4, e4, s1, s4, divA, divB;
  // 100 MHz clock
  initial forever #5 sys_clk = ~sys_clk;
  stg_tone_gen i_stg_tone_gen (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pinOutputMode, .pulseOut);
  stg_load_model i_stg_load_model_a (.sys_clk, .pin(pulseOut[1]), .halfLen(h1), .edges(e1));
  stg_load_model i_stg_load_model_b (.sys_clk, .pin(pulseOut[4]), .halfLen(h4), .edges(e4));
  // half period in clocks: tone is the reference rate over the divisor, two cycles of jitter
  function automatic bit near(int h, int d);
    int e;
    e = d * (`STG_CLK_HZ / 2) / `STG_REF_HZ;
    return h >= e - 2 && h <= e + 2;
  endfunction
  // verdict and end of run
  task automatic wrap_up;
    if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one apb transfer after an idle edge; read data kept in rd
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      wrap_up();
    end
  endtask
  // main sequence
  initial begin
    void'($urandom(63));
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    // reset values, then an unmapped word that reads zero
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      `CHK(rd, 32'h0)
      `CHK(er, i == 4)
    end
    // plain level everywhere, then tones on channels 1 and 4
    apb(1'b1, `STG_DUTY_OFFSET, 32'h0000FFFF);
    repeat (3) @(posedge sys_clk);
    `CHK(pulseOut[2], 1'b1)
    divA = $urandom_range(3, 1);
    divB = divA % 3 + 1;
    apb(1'b1, `STG_CTRL0_OFFSET, 32'h01010000 | divA);
    apb(1'b1, `STG_CTRL1_OFFSET, 32'h01040000 | divB);
    apb(1'b0, `STG_CTRL0_OFFSET, 32'h0);
    `CHK(rd, 32'h01010000 | divA)
    repeat (800) @(posedge sys_clk);
    `CHK(near(h1, divA), 1'b1)
    `CHK(near(h4, divB), 1'b1)
    if (divA != divB) `CHK(h1 < h4, divA < divB)
    `CHK(pulseOut[2], 1'b0)
    `CHK(pulseOut[5], 1'b0)
    // stop group 0, give group 1 a zero divisor
    apb(1'b1, `STG_CTRL0_OFFSET, 32'h02000000);
    apb(1'b1, `STG_CTRL1_OFFSET, 32'h01040000);
    repeat (5) @(posedge sys_clk);
    s1 = e1;
    s4 = e4;
    repeat (400) @(posedge sys_clk);
    `CHK(e1, s1)
    `CHK(pulseOut[2], 1'b1)
    `CHK(e4, s4)
    `CHK(pulseOut[4], 1'b0)
    // pins back to inputs
    pinOutputMode <= 16'h0000;
    repeat (3) @(posedge sys_clk);
    `CHK(pulseOut, 16'h0000)
    wrap_up();
  end
endmodule // tb_top
